/* File: mac_rx_path_collision_track_regs.vh */
// Purpose: Constants for the receive path and collision tracking block
// Assumes: 20 MHz system clock, 32-bit register port, byte addresses
// Notes:   Definitions only
`ifndef MAC_RX_PATH_COLLISION_TRACK_REGS_VH
`define MAC_RX_PATH_COLLISION_TRACK_REGS_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define R_CTRL      8'h00
`define R_SLOT      8'h04
`define R_STA0      8'h08
`define R_STA1      8'h0c
`define R_STA2      8'h10
`define R_HASH0     8'h14
`define R_HASH1     8'h18
`define R_HASH2     8'h1c
`define R_HASH3     8'h20
`define R_RXSTAT    8'h24
`define R_TXSTAT    8'h28
`define R_CRCCNT    8'h2c
`define R_ALNCNT    8'h30
`define R_MISSCNT   8'h34

// ---------------------------------------------------------------
// Control bits and reset values
// ---------------------------------------------------------------
`define C_NIBBLE    0
`define C_PROMISC   1
`define C_MCAST     2
`define C_BCAST     3
`define C_RUNTS     4
`define C_ERRS      5
`define C_MONITOR   6
`define C_LONG      7
`define CTRL_RST    8'h00
`define SLOT_RST    8'h40

// ---------------------------------------------------------------
// Frame constants
// ---------------------------------------------------------------
`define SFD_BYTE    8'hd5
`define CRC_INIT    32'hffffffff
`define CRC_POLY    32'h04c11db7
`define CRC_RESID   32'hc704dd7b
`define LONG_BYTES  16'd1518
`define ADDR_BYTES  16'd6
`define MAX_COLL    5'd16
`define CNT_MAX     8'hff
`define CNT_WARN    8'hbf
`define FIFO_BURST  4'd6
`define FIFO_DEPTH  4'd8

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_MHZ     20
`define HB_WIN_NS   3600
`define HB_WIN_CYC  ((`HB_WIN_NS * `CLK_MHZ) / 1000)

`endif

/* File: mac_rx_path_collision_track.v */
// Purpose: Receive path of an Ethernet MAC with collision count and heartbeat check
// Assumes: PHY pins sampled by sys_clk, link clock at most 5 MHz so each level spans two samples
// Notes:   Transmit side events arrive as one-cycle pulses on sys_clk
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "mac_rx_path_collision_track_regs.vh"

// ---------------------------------------------------------------
// Saturating event counter, cleared by a read
// ---------------------------------------------------------------
module sat_cnt (
	input  wire       sys_clk,
	input  wire       arst_n,
	input  wire       clk_en,
	input  wire       inc,
	input  wire       clr,
	output reg  [7:0] cnt
);
	// Increment in the read cycle survives as a count of one
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= 8'h00;
		end else if (clk_en) begin
			if (clr)
				cnt <= inc ? 8'h01 : 8'h00;
			else if (inc && cnt != `CNT_MAX)
				cnt <= cnt + 8'h01;
		end
	end
endmodule

// How it works
// - Collision count cleared before first attempt, bumped per collision, abandon at sixteen.
// - Abandoned frame pulses transmit complete and leaves sixteen in transmit status.
// - Serial mode: 3.6 us window after transmit; collision pulse clears heartbeat fail.
// - Serial mode takes one bit per link clock while carrier or collision active.
// - Serial bits shift through eight bits until delimiter, then bytes assemble LSB first.
// - Nibble mode shifts two nibbles from RX_DV rise, delimiter matched LSB first.
// - Nibble mode ends frame at RX_DV fall; data ignored while RX_DV low.
// - CRC runs over every byte after delimiter, including CRC field, until end.
// - Frame CRC good only if final remainder equals C704DD7B.
// - RX_ER during RX_DV forces a CRC error in nibble mode.
// - Six bytes after delimiter compared with programmed station address.
// - Multicast uses six CRC bits indexing a 64-bit filter table when enabled.
// - Broadcast by enable or hash bit; promiscuous takes all; others ignored.
// - Bytes counted from delimiter; runt until count exceeds slot, dropped unless allowed.
// - Eight-dword FIFO after delimiter, reset on mismatch, burst request at six.
// - Local memory full aborts frame, pulses overflow, bumps missed-frame counter.
// - Monitor mode stores nothing, counts each otherwise accepted frame as missed.
// - Bad CRC flags status, counts, aborts unless errored frames allowed.
// - Misaligned end with bad CRC flags alignment error and counts it.
// - Receive error pulse on CRC error unless monitor mode.
// - Long-frame check flags frames above 1518 bytes, skipping CRC and alignment counts.
// - Eight-bit counters saturate at 255, clear on read, pulse on reaching 192.
module mac_rx_path_collision_track (
	input  wire        sys_clk,
	input  wire        arst_n,
	input  wire        clk_en,
	input  wire [7:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	input  wire        rx_clk,
	input  wire [3:0]  rxd,
	input  wire        rx_dv,
	input  wire        rx_er,
	input  wire        crs,
	input  wire        col,
	input  wire        tx_first_attempt,
	input  wire        tx_collided,
	input  wire        tx_end,
	input  wire        mem_ack,
	input  wire        mem_full,
	output reg         burst_req,
	output reg         mem_wr,
	output reg  [31:0] mem_wdata,
	output reg         rx_frame_done,
	output reg         rx_frame_good,
	output reg         tx_abort,
	output reg         tx_complete_evt,
	output reg         rx_err_evt,
	output reg         overflow_evt,
	output reg         counter_evt
);
	// ---------------------------------------------------------------
	// Receiver states
	// ---------------------------------------------------------------
	localparam [3:0] S_WAIT = 4'b0001;
	localparam [3:0] S_HUNT = 4'b0010;
	localparam [3:0] S_RECV = 4'b0100;
	localparam [3:0] S_SKIP = 4'b1000;

	// Pin vector: clock, data, valid, error, carrier, collision
	localparam integer P_CLK = 8;
	localparam integer P_DV  = 3;
	localparam integer P_ER  = 2;
	localparam integer P_CRS = 1;
	localparam integer P_COL = 0;

	reg  [7:0]  ctrl;
	reg  [7:0]  slot_time;
	reg  [47:0] sta_addr;
	reg  [63:0] hash_tab;
	reg  [8:0]  s1, s2, s3, pins;
	reg  [3:0]  state;
	reg  [7:0]  shreg;
	reg  [2:0]  pos;
	reg  [15:0] byte_cnt;
	reg  [31:0] crc;
	reg  [47:0] dst;
	reg         addr_ok;
	reg         er_seen;
	reg  [23:0] wbuf;
	reg  [1:0]  wpos;
	reg  [31:0] fifo [0:7];
	reg  [2:0]  wp, rp;
	reg  [3:0]  lvl;
	reg         tail;
	reg  [9:0]  rx_stat;
	reg  [4:0]  coll_cnt;
	reg         coll_abort;
	reg         heartbeat_fail_flag;
	reg         hb_open, hb_seen;
	reg  [7:0]  hb_cnt;
	reg  [31:0] next_crc;
	reg  [31:0] next_rdata;
	reg  [8:0]  next_pins;
	reg  [7:0]  nb;
	integer     i;

	wire        nib_mode = ctrl[`C_NIBBLE];
	wire        monitor  = ctrl[`C_MONITOR];
	wire [7:0]  crc_cnt, aln_cnt, missed_frame_counter;

	// ---------------------------------------------------------------
	// Pin sampling
	// ---------------------------------------------------------------
	// A pin level is taken once the second and third stages agree
	always @* begin
		next_pins = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & pins);
	end

	wire clk_rise = next_pins[P_CLK] & ~pins[P_CLK];
	wire link_on  = nib_mode ? next_pins[P_DV] : (next_pins[P_CRS] | next_pins[P_COL]);
	wire step     = clk_rise & link_on;
	wire [2:0] inc_pos = nib_mode ? 3'd4 : 3'd1;
	wire byte_done = step & (pos == (3'd0 - inc_pos));
	wire [7:0] shift_in = nib_mode ? {next_pins[7:4], shreg[7:4]}
		: {next_pins[4], shreg[7:1]};

	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s1   <= 9'h000;
			s2   <= 9'h000;
			s3   <= 9'h000;
			pins <= 9'h000;
		end else if (clk_en) begin
			s1   <= {rx_clk, rxd, rx_dv, rx_er, crs, col};
			s2   <= s1;
			s3   <= s2;
			pins <= next_pins;
		end
	end

	// ---------------------------------------------------------------
	// Byte-wise frame check, LSB of each byte first
	// ---------------------------------------------------------------
	always @* begin
		nb       = shift_in;
		next_crc = crc;
		for (i = 0; i < 8; i = i + 1) begin
			if (next_crc[31] ^ nb[i])
				next_crc = {next_crc[30:0], 1'b0} ^ `CRC_POLY;
			else
				next_crc = {next_crc[30:0], 1'b0};
		end
	end

	// ---------------------------------------------------------------
	// Address decision on the sixth byte
	// ---------------------------------------------------------------
	wire [47:0] dst_full = {nb, dst[47:8]};
	wire [5:0]  hash_idx = next_crc[31:26];
	wire        hash_hit = hash_tab[hash_idx];
	wire        is_mc    = dst_full[0];
	wire        is_bc    = &dst_full;
	wire        addr_hit = ctrl[`C_PROMISC]
		| (~is_mc & (dst_full == sta_addr))
		| (is_mc & ~is_bc & ctrl[`C_MCAST] & hash_hit)
		| (is_bc & (ctrl[`C_BCAST] | hash_hit));
	wire        addr_byte = byte_done & (byte_cnt == `ADDR_BYTES);

	// End of frame evaluation
	wire        frame_end = state[2] & ~link_on;
	wire        crc_bad  = (crc != `CRC_RESID) | er_seen;
	wire        misalign = crc_bad & (pos != 3'd0);
	wire        runt     = byte_cnt <= {8'h00, slot_time};
	wire        too_long = ctrl[`C_LONG] & ((byte_cnt - 16'd1) > `LONG_BYTES);
	wire        accept   = addr_ok & ~(crc_bad & ~ctrl[`C_ERRS])
		& ~(runt & ~ctrl[`C_RUNTS]);
	wire        overflow = state[2] & mem_full & ~monitor;
	wire        store_on = ~monitor;

	// FIFO push and flush requests
	reg         push;
	reg  [31:0] push_data;
	reg         flush;
	always @* begin
		push      = 1'b0;
		push_data = {nb, wbuf};
		flush     = 1'b0;
		if (state[2] && byte_done && store_on && wpos == 2'd3)
			push = 1'b1;
		if (frame_end && !monitor && accept && wpos != 2'd0) begin
			push      = 1'b1;
			push_data = {8'h00, wbuf} >> {2'd3 - wpos, 3'h0}; // Tail shifted down, byte 0 in 7:0
		end
		if (addr_byte && state[2] && !addr_hit)
			flush = 1'b1;
		if (frame_end && !monitor && !accept)
			flush = 1'b1;
	end

	// ---------------------------------------------------------------
	// Receive state machine
	// ---------------------------------------------------------------
	// Discards park in SKIP so stray nibbles cannot start a frame
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state    <= S_WAIT;
			shreg    <= 8'h00;
			pos      <= 3'd0;
			byte_cnt <= 16'd0;
			crc      <= `CRC_INIT;
			dst      <= 48'h0;
			addr_ok  <= 1'b0;
			er_seen  <= 1'b0;
			wbuf     <= 24'h0;
			wpos     <= 2'd0;
		end else if (clk_en) begin
			case (state)
				S_WAIT: begin
					if (!link_on)
						state <= S_HUNT;
				end
				S_HUNT: begin
					if (step) begin
						shreg <= shift_in;
						if (shift_in == `SFD_BYTE) begin
							state    <= S_RECV;
							pos      <= 3'd0;
							byte_cnt <= 16'd1;
							crc      <= `CRC_INIT;
							addr_ok  <= 1'b0;
							er_seen  <= 1'b0;
							wpos     <= 2'd0;
						end
					end
				end
				S_RECV: begin
					if (nib_mode && next_pins[P_DV] && next_pins[P_ER])
						er_seen <= 1'b1;
					if (frame_end) begin
						state <= S_WAIT;
					end else if (overflow) begin
						state <= S_SKIP;
					end else if (step) begin
						shreg <= shift_in;
						pos   <= pos + inc_pos;
						if (byte_done) begin
							crc      <= next_crc;
							byte_cnt <= (byte_cnt == 16'hffff) ? byte_cnt : byte_cnt + 16'd1;
							wpos     <= wpos + 2'd1;
							wbuf     <= {nb, wbuf[23:8]};
							if (byte_cnt <= `ADDR_BYTES)
								dst <= dst_full;
							if (addr_byte) begin
								addr_ok <= addr_hit;
								if (!addr_hit)
									state <= S_SKIP;
							end
						end
					end
				end
				S_SKIP: begin
					if (!link_on)
						state <= S_HUNT;
				end
				default: state <= S_WAIT;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Receive FIFO toward local memory
	// ---------------------------------------------------------------
	wire do_push = push & (lvl != `FIFO_DEPTH);
	wire do_pop  = mem_ack & (lvl != 4'd0) & ~flush;

	// Tail request drains a short final burst after a good frame
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wp        <= 3'd0;
			rp        <= 3'd0;
			lvl       <= 4'd0;
			tail      <= 1'b0;
			mem_wr    <= 1'b0;
			mem_wdata <= 32'h0;
			burst_req <= 1'b0;
		end else if (clk_en) begin
			mem_wr <= do_pop;
			if (do_pop)
				mem_wdata <= fifo[rp];
			if (flush) begin
				wp   <= 3'd0;
				rp   <= 3'd0;
				lvl  <= 4'd0;
				tail <= 1'b0;
			end else begin
				if (do_push)
					wp <= wp + 3'd1;
				if (do_pop)
					rp <= rp + 3'd1;
				lvl <= lvl + {3'd0, do_push} - {3'd0, do_pop};
				if (frame_end && accept && !monitor)
					tail <= 1'b1;
				else if (lvl == 4'd0)
					tail <= 1'b0;
			end
			burst_req <= (lvl >= `FIFO_BURST) | (tail & lvl != 4'd0);
		end
	end

	always @(posedge sys_clk) begin
		if (clk_en && do_push && !flush)
			fifo[wp] <= push_data;
	end

	// ---------------------------------------------------------------
	// Frame status and event pulses
	// ---------------------------------------------------------------
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_stat       <= 10'h000;
			rx_frame_done <= 1'b0;
			rx_frame_good <= 1'b0;
			rx_err_evt    <= 1'b0;
			overflow_evt  <= 1'b0;
		end else if (clk_en) begin
			rx_frame_done <= frame_end & ~monitor;
			rx_err_evt    <= frame_end & crc_bad & ~monitor;
			overflow_evt  <= overflow;
			if (frame_end) begin
				rx_frame_good <= accept & ~monitor;
				rx_stat <= {1'b0, addr_ok & dst[0] & ~&dst, addr_ok & &dst,
					too_long, runt, misalign, crc_bad, accept};
			end else if (overflow) begin
				rx_frame_good <= 1'b0;
				rx_stat <= 10'h200;
			end
		end
	end

	// ---------------------------------------------------------------
	// Event counters
	// ---------------------------------------------------------------
	wire rd_crc  = reg_rd & (reg_addr == `R_CRCCNT);
	wire rd_aln  = reg_rd & (reg_addr == `R_ALNCNT);
	wire rd_miss = reg_rd & (reg_addr == `R_MISSCNT);
	wire inc_crc  = frame_end & crc_bad & ~too_long;
	wire inc_aln  = frame_end & misalign & ~too_long;
	wire inc_miss = overflow | (frame_end & monitor & accept);

	sat_cnt u_crc_cnt (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.clk_en  (clk_en),
		.inc     (inc_crc),
		.clr     (rd_crc),
		.cnt     (crc_cnt)
	);

	sat_cnt u_aln_cnt (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.clk_en  (clk_en),
		.inc     (inc_aln),
		.clr     (rd_aln),
		.cnt     (aln_cnt)
	);

	sat_cnt u_miss_cnt (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.clk_en  (clk_en),
		.inc     (inc_miss),
		.clr     (rd_miss),
		.cnt     (missed_frame_counter)
	);

	// Pulse when any counter steps from 191 to 192
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			counter_evt <= 1'b0;
		else if (clk_en)
			counter_evt <= (inc_crc & ~rd_crc & crc_cnt == `CNT_WARN)
				| (inc_aln & ~rd_aln & aln_cnt == `CNT_WARN)
				| (inc_miss & ~rd_miss & missed_frame_counter == `CNT_WARN);
	end

	// ---------------------------------------------------------------
	// Collision count and heartbeat check
	// ---------------------------------------------------------------
	// Window only opens in serial mode; nibble PHYs give no heartbeat
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			coll_cnt            <= 5'd0;
			coll_abort          <= 1'b0;
			tx_abort            <= 1'b0;
			tx_complete_evt     <= 1'b0;
			heartbeat_fail_flag <= 1'b0;
			hb_open             <= 1'b0;
			hb_seen             <= 1'b0;
			hb_cnt              <= 8'd0;
		end else if (clk_en) begin
			tx_abort        <= 1'b0;
			tx_complete_evt <= 1'b0;
			if (tx_first_attempt) begin
				coll_cnt   <= 5'd0;
				coll_abort <= 1'b0;
			end else if (tx_collided && coll_cnt != `MAX_COLL) begin
				coll_cnt <= coll_cnt + 5'd1;
				if (coll_cnt == `MAX_COLL - 5'd1) begin
					coll_abort      <= 1'b1;
					tx_abort        <= 1'b1;
					tx_complete_evt <= 1'b1;
				end
			end
			if (tx_end && !nib_mode) begin
				hb_open <= 1'b1;
				hb_seen <= 1'b0;
				hb_cnt  <= 8'd0;
			end else if (hb_open) begin
				if (next_pins[P_COL])
					hb_seen <= 1'b1;
				hb_cnt <= hb_cnt + 8'd1;
				if (hb_cnt == `HB_WIN_CYC - 1) begin
					hb_open             <= 1'b0;
					heartbeat_fail_flag <= ~(hb_seen | next_pins[P_COL]);
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Register port
	// ---------------------------------------------------------------
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl      <= `CTRL_RST;
			slot_time <= `SLOT_RST;
			sta_addr  <= 48'h0;
			hash_tab  <= 64'h0;
		end else if (clk_en && reg_wr) begin
			case (reg_addr)
				`R_CTRL:  ctrl            <= reg_wdata[7:0];
				`R_SLOT:  slot_time       <= reg_wdata[7:0];
				`R_STA0:  sta_addr[15:0]  <= reg_wdata[15:0];
				`R_STA1:  sta_addr[31:16] <= reg_wdata[15:0];
				`R_STA2:  sta_addr[47:32] <= reg_wdata[15:0];
				`R_HASH0: hash_tab[15:0]  <= reg_wdata[15:0];
				`R_HASH1: hash_tab[31:16] <= reg_wdata[15:0];
				`R_HASH2: hash_tab[47:32] <= reg_wdata[15:0];
				`R_HASH3: hash_tab[63:48] <= reg_wdata[15:0];
				default: ;
			endcase
		end
	end

	// Read mux; unmapped addresses read as zero
	always @* begin
		case (reg_addr)
			`R_CTRL:    next_rdata = {24'h0, ctrl};
			`R_SLOT:    next_rdata = {24'h0, slot_time};
			`R_STA0:    next_rdata = {16'h0, sta_addr[15:0]};
			`R_STA1:    next_rdata = {16'h0, sta_addr[31:16]};
			`R_STA2:    next_rdata = {16'h0, sta_addr[47:32]};
			`R_HASH0:   next_rdata = {16'h0, hash_tab[15:0]};
			`R_HASH1:   next_rdata = {16'h0, hash_tab[31:16]};
			`R_HASH2:   next_rdata = {16'h0, hash_tab[47:32]};
			`R_HASH3:   next_rdata = {16'h0, hash_tab[63:48]};
			`R_RXSTAT:  next_rdata = {22'h0, rx_stat};
			`R_TXSTAT:  next_rdata = {25'h0, coll_abort, heartbeat_fail_flag, coll_cnt};
			`R_CRCCNT:  next_rdata = {24'h0, crc_cnt};
			`R_ALNCNT:  next_rdata = {24'h0, aln_cnt};
			`R_MISSCNT: next_rdata = {24'h0, missed_frame_counter};
			default:    next_rdata = 32'h0;
		endcase
	end

	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			reg_rdata <= 32'h0;
		else if (clk_en)
			reg_rdata <= reg_rd ? next_rdata : 32'h0;
	end
endmodule
`default_nettype wire

/* File: mac_rx_path_collision_track_checker.sv */
// Purpose: Port-level checks of the receive path and collision block
// Assumes: One clock domain, sys_clk samples every port
// Notes:   Bound to every instance of the block
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------
// Checker
// ------------------------------------------------
module rx_path_checker (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic rx_dv,
	input wire logic crs,
	input wire logic tx_first_attempt,
	input wire logic tx_collided,
	input wire logic mem_ack,
	input wire logic mem_full,
	input wire logic mem_wr,
	input wire logic rx_frame_done,
	input wire logic rx_frame_good,
	input wire logic tx_abort,
	input wire logic tx_complete_evt,
	input wire logic rx_err_evt,
	input wire logic overflow_evt
);
	logic [4:0] n;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// Collisions since first attempt; stops at 31 so it never wraps
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			n <= 5'd0;
		else if (clk_en && tx_first_attempt)
			n <= 5'd0;
		else if (clk_en && tx_collided && n != 5'd31)
			n <= n + 5'd1;
	end
	a_abort_at_16: assert property (tx_abort |-> n == 5'd16)
		else $error("abort not at sixteenth collision");
	a_abort_complete: assert property (tx_abort |-> tx_complete_evt)
		else $error("abort without transmit complete");
	a_err_at_end: assert property (rx_err_evt |-> rx_frame_done)
		else $error("receive error away from frame end");
	a_done_link_off: assert property (rx_frame_done |-> $past(!rx_dv && !crs, 2))
		else $error("frame end while link active");
	a_done_single: assert property (rx_frame_done |=> !rx_frame_done)
		else $error("second frame end without new frame");
	a_good_at_end: assert property ($rose(rx_frame_good) |-> rx_frame_done)
		else $error("accept outside frame end");
	a_wr_after_ack: assert property (mem_wr |-> $past(mem_ack))
		else $error("memory write without acknowledge");
	a_ovf_cause: assert property (overflow_evt |-> $past(mem_full))
		else $error("overflow without memory full");
endmodule

bind mac_rx_path_collision_track rx_path_checker u_chk (.*);
`default_nettype wire

/* File: phy_model.sv */
// Purpose: Nibble-wide or serial PHY receive side
// Assumes: 400 ns receive clock, still between frames
// Notes:   Eight counted bytes plus FCS per frame
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------
// PHY model
// ------------------------------------------------
module phy_model (
	output logic       rx_clk,
	output logic [3:0] rxd,
	output logic       rx_dv,
	output logic       crs
);
	logic ser;
	initial begin
		rx_clk = 1'b0;
		rxd = 4'h0;
		rx_dv = 1'b0;
		crs = 1'b0;
	end
	// Data moves at the falling edge so it is settled at the rising one
	// Serial mode sends the nibble LSB first on rxd[0] under carrier
	task automatic nib(input logic [3:0] v);
		for (int k = 0; k < (ser ? 4 : 1); k++) begin
			rxd = ser ? {3'h0, v[k]} : v;
			rx_dv = !ser;
			crs = ser;
			#200 rx_clk = 1'b1;
			#200 rx_clk = 1'b0;
		end
	endtask
	// Nonzero bad flips FCS bits to spoil the remainder
	task automatic send(input logic [7:0] bad, input logic s = 1'b0);
		logic [31:0] c;
		logic [7:0]  b;
		ser = s;
		c = 32'hffffffff;
		repeat (15) nib(4'h5);
		nib(4'hd);
		for (int i = 0; i < 12; i++) begin
			if (i < 8)
				b = 8'h10 + 8'(i);
			else
				b = 8'(~c >> (8 * (i - 8))) ^ bad;
			for (int j = 0; j < 8 && i < 8; j++)
				c = (c >> 1) ^ ((c[0] ^ b[j]) ? 32'hedb88320 : 32'h0);
			nib(b[3:0]);
			nib(b[7:4]);
		end
		rx_dv = 1'b0;
		crs = 1'b0;
		rxd = ~rxd; // Released lines must not keep the last value
	endtask
endmodule
`default_nettype wire

/* File: mac_rx_path_collision_track_bench.sv */
// Purpose: Self-checking bench of the receive path and collision block
// Assumes: Nibble and serial PHY model, memory acknowledge set per test
// Notes:   Frames of eight bytes plus FCS, so runts are tuned by slot value
`timescale 1ns/10ps
`default_nettype none
`include "mac_rx_path_collision_track_regs.vh"
// ------------------------------------------------
// Bench
// ------------------------------------------------
module mac_rx_path_collision_track_bench;
	logic        sys_clk, arst_n, reg_wr, reg_rd, col, clr;
	logic        clk_en, rx_er, mem_ack;
	logic        tx_first_attempt, tx_collided, tx_end, mem_full;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, d, w0;
	logic [4:0]  seen;
	wire  [31:0] reg_rdata, mem_wdata;
	wire  [3:0]  rxd;
	wire         rx_clk, rx_dv, crs, burst_req, mem_wr, rx_frame_done, rx_frame_good;
	wire         tx_abort, tx_complete_evt, rx_err_evt, overflow_evt, counter_evt;
	int          miscompares, comparisons;
	mac_rx_path_collision_track u_dut (.*);
	phy_model u_phy (.*);
	always #25 sys_clk = ~sys_clk;
	// Sticky event flags: done, error, overflow, abort, memory word
	always @(posedge sys_clk) begin
		if (clr)
			seen <= 5'h0;
		else
			seen <= seen | {mem_wr, tx_abort, overflow_evt, rx_err_evt, rx_frame_done};
		if (mem_wr === 1'b1 && seen[4] !== 1'b1)
			w0 <= mem_wdata;
	end
	task automatic summarize;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", s, e, g);
			miscompares++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic clear;
		@(posedge sys_clk) clr <= 1'b1;
		@(posedge sys_clk) clr <= 1'b0;
	endtask
	// Bounded wait; a miss ends the run
	task automatic wt(input int w);
		for (int k = 0; k < 200 && seen[w] !== 1'b1; k++)
			@(posedge sys_clk);
		chk("event", 32'h1, 32'(seen[w]));
		if (seen[w] !== 1'b1)
			summarize();
	endtask
	task automatic t_regs;
		rd(`R_CTRL);
		chk("ctrl", 32'(`CTRL_RST), d);
		// A write with the enable low must leave the slot value alone
		@(posedge sys_clk) clk_en <= 1'b0;
		wr(`R_SLOT, 32'h5);
		clk_en <= 1'b1;
		rd(`R_SLOT);
		chk("slot", 32'(`SLOT_RST), d);
		rd(8'hfc);
		chk("unmapped", 32'h0, d);
		$display("done: regs");
	endtask
	task automatic t_coll;
		clear();
		@(posedge sys_clk) tx_first_attempt <= 1'b1;
		@(posedge sys_clk) tx_first_attempt <= 1'b0;
		for (int i = 1; i <= 16; i++) begin
			@(posedge sys_clk) tx_collided <= 1'b1;
			@(posedge sys_clk) tx_collided <= 1'b0;
			if (i == 15)
				chk("early abort", 32'h0, 32'(seen[3]));
		end
		wt(3);
		rd(`R_TXSTAT);
		chk("coll count", 32'(`MAX_COLL), 32'(d[4:0]));
		chk("abandoned", 32'h1, 32'(d[6]));
		$display("done: collisions");
	endtask
	// Serial mode: silent window sets the flag, a pulse inside clears it
	task automatic t_hb;
		wr(`R_CTRL, 32'h0);
		for (int p = 0; p < 2; p++) begin
			@(posedge sys_clk) tx_end <= 1'b1;
			@(posedge sys_clk) tx_end <= 1'b0;
			repeat (10) @(posedge sys_clk);
			col <= 1'(p);
			repeat (4) @(posedge sys_clk);
			col <= 1'b0;
			repeat (`HB_WIN_CYC) @(posedge sys_clk);
			rd(`R_TXSTAT);
			chk("heartbeat_fail_flag", 32'(1 - p), 32'(d[5]));
		end
		$display("done: heartbeat");
	endtask
	task automatic t_good;
		wr(`R_CTRL, 32'h13); // Nibble, promiscuous, runts kept
		clear();
		mem_ack <= 1'b0;
		u_phy.send(8'h0);
		wt(0);
		#1 chk("burst tail", 32'h1, 32'(burst_req));
		mem_ack <= 1'b1;
		wt(4);
		chk("accept", 32'h1, 32'(rx_frame_good));
		chk("word0", 32'h13121110, w0);
		$display("done: good frame");
	endtask
	task automatic t_bad;
		clear();
		u_phy.send(8'h01);
		wt(1);
		chk("accept", 32'h0, 32'(rx_frame_good));
		rd(`R_RXSTAT);
		chk("crc flag", 32'h1, 32'(d[1]));
		rd(`R_ALNCNT);
		chk("align count", 32'h0, d);
		rd(`R_CRCCNT);
		chk("crc count", 32'h1, d);
		rd(`R_CRCCNT);
		chk("crc cleared", 32'h0, d);
		clear();
		rx_er <= 1'b1;
		u_phy.send(8'h0);
		rx_er <= 1'b0;
		wt(1);
		$display("done: bad frame");
	endtask
	task automatic t_ser;
		wr(`R_CTRL, 32'h02); // Serial, promiscuous
		clear();
		u_phy.send(8'h0, 1'b1);
		wt(0);
		chk("serial accept", 32'h1, 32'(rx_frame_good));
		chk("serial word0", 32'h13121110, w0);
		$display("done: serial frame");
	endtask
	// Thirteen bytes counted from the delimiter: runt at slot 13, not at 12
	task automatic t_runt;
		wr(`R_CTRL, 32'h03);
		for (int s = 13; s >= 12; s--) begin
			wr(`R_SLOT, 32'(s));
			clear();
			u_phy.send(8'h0);
			wt(0);
			chk("runt accept", 32'(13 - s), 32'(rx_frame_good));
		end
		$display("done: runts");
	endtask
	task automatic t_ovf;
		clear();
		mem_full <= 1'b1;
		u_phy.send(8'h0);
		wt(2);
		mem_full <= 1'b0;
		rd(`R_MISSCNT);
		chk("missed_frame_counter", 32'h1, d);
		$display("done: overflow");
	endtask
	initial begin
		{sys_clk, arst_n, reg_wr, reg_rd, col, clr} = 6'h0;
		{tx_first_attempt, tx_collided, tx_end, mem_full} = 4'h0;
		{clk_en, mem_ack, rx_er} = 3'h6;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		repeat (16) @(posedge sys_clk);
		arst_n <= 1'b1;
		t_regs();
		t_coll();
		t_hb();
		t_good();
		t_bad();
		t_runt();
		t_ovf();
		t_ser();
		summarize();
	end
endmodule
`default_nettype wire
